// ### core/dcp_defs.svh
// Register offsets, reset values and field positions of the dual compare PWM timer.
`ifndef DCP_DEFS_SVH
`define DCP_DEFS_SVH
`define DCP_OFF_CTRL     8'h00
`define DCP_OFF_COUNTER  8'h04
`define DCP_OFF_PERIOD   8'h08
`define DCP_OFF_ASET     8'h0C
`define DCP_OFF_BRST     8'h10
`define DCP_OFF_BSET     8'h14
`define DCP_OFF_FLAGS    8'h18
`define DCP_OFF_IRQ_STAT 8'h1C
`define DCP_OFF_IRQ_MASK 8'h20
`define DCP_CTRL_RST     14'h0004
`define DCP_CMP_RST      16'hFFFF
`define DCP_CNT_MAX      16'hFFFF
`define DCP_FLAG_PERIOD  0
`define DCP_FLAG_OVF     1
`define DCP_CMP_PERIOD   0
`define DCP_CMP_ASET     1
`define DCP_CMP_BRST     2
`define DCP_CMP_BSET     3
`define DCP_SRC_UNDIV    3'h0
`endif

// ### core/dcp_pkg.sv
// Types shared by the dual compare PWM timer.
package dcp_pkg;
    typedef struct packed {
        logic       trig_en;
        logic       cutoff_en;
        logic [3:0] buf_en;
        logic [2:0] src_sel;
        logic       pol_b;
        logic       pol_a;
        logic       clear_on_match;
        logic       count_continue;
        logic       start;
    } dcp_ctrl_t;
    typedef struct packed {
        logic cutoff;
        logic b_reset;
        logic b_set;
        logic a_set;
        logic overflow;
        logic period;
    } dcp_evt_t;
endpackage

// ### core/dcp_timer.sv
// Dual compare PWM timer: 16-bit counter, period and three change-point compares.
`timescale 1ns/1ps
`default_nettype none
`include "dcp_defs.svh"
// Operation
// - Source select zero counts every ref_clk cycle, the undivided count source.
// - A period ends when the counter equals period_compare.
// - A period setting of N gives N+1 count cycles.
// - With clearing selected, the period match loads zero; counting goes on only with count-continue set.
// - Change points come from equality with three further compare registers.
// - Each output is active high with low initial level, driven before any change.
// - Output A goes active when counter equals a_set_point_compare.
// - Output B goes active when counter equals b_set_point_compare.
// - Output B returns to initial level when counter equals b_reset_point_compare.
// - Output A stays active period minus A set point cycles, ending at period match.
// - Output B stays active B reset point minus B set point cycles.
// - The period match raises an interrupt request.
// - Compare buffering, forced cutoff and converter trigger are separately enabled.
// - The counter increments per count cycle over its full range; wrap sets overflow.
// - Without count-continue the counter stops after the period match.
// - Period match sets a flag; software reads it, then writes zero to clear.
module dcp_timer (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        cutoff_in,
    output logic             pwm_output_a,
    output logic             pwm_output_b,
    output logic             conv_trig,
    output logic             irq
);
    dcp_pkg::dcp_ctrl_t ctrl_q;
    dcp_pkg::dcp_evt_t  evt;
    logic [15:0] pwm_counter_q;
    logic [15:0] cmp_q [4];
    logic [15:0] buf_q [4];
    logic [7:0]  pre_q;
    logic        tick;
    logic        m_per;
    logic        m_aset;
    logic        m_brst;
    logic        m_bset;
    logic        lvl_a_q;
    logic        lvl_b_q;
    logic        cut_act;
    logic [1:0]  flags_q;
    logic [1:0]  armed_q;
    logic [5:0]  stat_q;
    logic [5:0]  mask_q;
    logic [31:0] rdata_q;
    logic        wr_ctrl;
    logic        wr_cnt;
    logic        wr_flags;
    logic        rd_flags;
    logic        rd_stat;
    logic [3:0]  wr_cmp;

    assign wr_ctrl  = reg_wr && (reg_addr == `DCP_OFF_CTRL);
    assign wr_cnt   = reg_wr && (reg_addr == `DCP_OFF_COUNTER);
    assign wr_flags = reg_wr && (reg_addr == `DCP_OFF_FLAGS);
    assign rd_flags = reg_rd && (reg_addr == `DCP_OFF_FLAGS);
    assign rd_stat  = reg_rd && (reg_addr == `DCP_OFF_IRQ_STAT);
    assign wr_cmp[`DCP_CMP_PERIOD] = reg_wr && (reg_addr == `DCP_OFF_PERIOD);
    assign wr_cmp[`DCP_CMP_ASET]   = reg_wr && (reg_addr == `DCP_OFF_ASET);
    assign wr_cmp[`DCP_CMP_BRST]   = reg_wr && (reg_addr == `DCP_OFF_BRST);
    assign wr_cmp[`DCP_CMP_BSET]   = reg_wr && (reg_addr == `DCP_OFF_BSET);

    // Count source: selection zero is the undivided clock, others divide by 2^sel.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pre_q <= 8'h00;
        else if (!ctrl_q.start)
            pre_q <= 8'h00;
        else
            pre_q <= pre_q + 8'h01;
    end

    always_comb
    begin
        if (ctrl_q.src_sel == `DCP_SRC_UNDIV)
            tick = ctrl_q.start;
        else
            tick = ctrl_q.start && ((pre_q & ((8'h01 << ctrl_q.src_sel) - 8'h01)) == 8'h00);
    end

    assign m_per  = tick && (pwm_counter_q == cmp_q[`DCP_CMP_PERIOD]);
    assign m_aset = tick && (pwm_counter_q == cmp_q[`DCP_CMP_ASET]);
    assign m_brst = tick && (pwm_counter_q == cmp_q[`DCP_CMP_BRST]);
    assign m_bset = tick && (pwm_counter_q == cmp_q[`DCP_CMP_BSET]);
    assign cut_act = ctrl_q.cutoff_en && cutoff_in;

    // Control; hardware stops the counter at the period match unless continuing.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_q <= `DCP_CTRL_RST;
        else if (wr_ctrl)
            ctrl_q <= reg_wdata[13:0];
        else if (m_per && !ctrl_q.count_continue)
            ctrl_q.start <= 1'b0;
    end

    // Counter.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pwm_counter_q <= 16'h0000;
        else if (wr_cnt)
            pwm_counter_q <= reg_wdata[15:0];
        else if (m_per && ctrl_q.clear_on_match)
            pwm_counter_q <= 16'h0000;
        else if (tick)
            pwm_counter_q <= pwm_counter_q + 16'h0001;
    end

    // Compare registers; with buffering the written value waits for the period match.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 4; i++)
            begin
                cmp_q[i] <= `DCP_CMP_RST;
                buf_q[i] <= `DCP_CMP_RST;
            end
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (wr_cmp[i])
                    buf_q[i] <= reg_wdata[15:0];
                if (wr_cmp[i] && !ctrl_q.buf_en[i])
                    cmp_q[i] <= reg_wdata[15:0];
                else if (m_per && ctrl_q.buf_en[i])
                    cmp_q[i] <= buf_q[i];
            end
        end
    end

    // Output levels; the period match wins and returns both to initial level.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lvl_a_q <= 1'b0;
            lvl_b_q <= 1'b0;
        end
        else if (m_per)
        begin
            lvl_a_q <= 1'b0;
            lvl_b_q <= 1'b0;
        end
        else
        begin
            if (m_aset)
                lvl_a_q <= 1'b1;
            if (m_brst)
                lvl_b_q <= 1'b0;
            else if (m_bset)
                lvl_b_q <= 1'b1;
        end
    end

    // Pins follow the levels; polarity inverts, cutoff forces the initial level.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwm_output_a <= 1'b0;
            pwm_output_b <= 1'b0;
            conv_trig    <= 1'b0;
        end
        else
        begin
            pwm_output_a <= (lvl_a_q && !cut_act) ^ ctrl_q.pol_a;
            pwm_output_b <= (lvl_b_q && !cut_act) ^ ctrl_q.pol_b;
            conv_trig    <= m_per && ctrl_q.trig_en;
        end
    end

    assign evt.period   = m_per;
    assign evt.overflow = tick && !wr_cnt && (pwm_counter_q == `DCP_CNT_MAX)
                          && !(m_per && ctrl_q.clear_on_match);
    assign evt.a_set    = m_aset && !m_per;
    assign evt.b_set    = m_bset && !m_brst && !m_per;
    assign evt.b_reset  = m_brst && !m_per;
    assign evt.cutoff   = cut_act;

    // Flags clear by a read that saw them set followed by a write of zero.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags_q <= 2'h0;
            armed_q <= 2'h0;
        end
        else
        begin
            if (rd_flags)
                armed_q <= flags_q;
            else if (wr_flags)
                armed_q <= 2'h0;
            if (wr_flags)
                flags_q <= flags_q & (reg_wdata[1:0] | ~armed_q);
            flags_q[`DCP_FLAG_PERIOD] <= evt.period ||
                (flags_q[`DCP_FLAG_PERIOD] && !(wr_flags && armed_q[0] && !reg_wdata[0]));
            flags_q[`DCP_FLAG_OVF] <= evt.overflow ||
                (flags_q[`DCP_FLAG_OVF] && !(wr_flags && armed_q[1] && !reg_wdata[1]));
        end
    end

    // Interrupt status: sticky, cleared by reading, a new event wins over the clear.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            stat_q <= 6'h00;
        else
            stat_q <= evt | (rd_stat ? 6'h00 : stat_q);
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            mask_q <= 6'h00;
        else if (reg_wr && (reg_addr == `DCP_OFF_IRQ_MASK))
            mask_q <= reg_wdata[5:0];
    end

    // The interrupt is a plain level from registers, so it cannot glitch on the bus strobes.
    // It drops in the cycle after a status read unless a new event lands in that read cycle.
    assign irq = |(stat_q & mask_q);

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= 32'h0000_0000;
        else if (!reg_rd)
            rdata_q <= 32'h0000_0000;
        else
        begin
            case (reg_addr)
                `DCP_OFF_CTRL:     rdata_q <= {18'h0_0000, ctrl_q};
                `DCP_OFF_COUNTER:  rdata_q <= {16'h0000, pwm_counter_q};
                `DCP_OFF_PERIOD:   rdata_q <= {16'h0000, cmp_q[`DCP_CMP_PERIOD]};
                `DCP_OFF_ASET:     rdata_q <= {16'h0000, cmp_q[`DCP_CMP_ASET]};
                `DCP_OFF_BRST:     rdata_q <= {16'h0000, cmp_q[`DCP_CMP_BRST]};
                `DCP_OFF_BSET:     rdata_q <= {16'h0000, cmp_q[`DCP_CMP_BSET]};
                `DCP_OFF_FLAGS:    rdata_q <= {28'h000_0000, lvl_b_q, lvl_a_q, flags_q};
                `DCP_OFF_IRQ_STAT: rdata_q <= {26'h000_0000, stat_q};
                `DCP_OFF_IRQ_MASK: rdata_q <= {26'h000_0000, mask_q};
                default:           rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign reg_rdata = rdata_q;

    chk_period_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        m_per && ctrl_q.clear_on_match && !wr_cnt |=> pwm_counter_q == 16'h0000)
        else $error("counter not cleared at period match");

    chk_count_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tick && !m_per && !wr_cnt |=> pwm_counter_q == $past(pwm_counter_q) + 16'h0001)
        else $error("counter did not step by one");

    chk_stop_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !ctrl_q.start && !wr_cnt |=> $stable(pwm_counter_q) && $stable(lvl_a_q)
        && $stable(lvl_b_q))
        else $error("stopped counter or levels moved");

    chk_a_goes_active: assert property (@(posedge ref_clk) disable iff (!rst_n)
        m_aset && !m_per |=> lvl_a_q ##1 (cut_act || ctrl_q.pol_a || pwm_output_a))
        else $error("output A not active after set point");

    chk_b_goes_active: assert property (@(posedge ref_clk) disable iff (!rst_n)
        m_bset && !m_brst && !m_per |=> lvl_b_q)
        else $error("output B not active after set point");

    chk_b_returns: assert property (@(posedge ref_clk) disable iff (!rst_n)
        m_brst |=> !lvl_b_q)
        else $error("output B not back at reset point");

    chk_a_period_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
        m_per |=> !lvl_a_q && !lvl_b_q)
        else $error("outputs not initial after period match");

    chk_period_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        m_per |=> flags_q[`DCP_FLAG_PERIOD] && stat_q[0])
        else $error("period flag not set");

    chk_irq_raise: assert property (@(posedge ref_clk) disable iff (!rst_n)
        m_per && mask_q[0] && !(reg_wr && reg_addr == `DCP_OFF_IRQ_MASK) |=> irq)
        else $error("interrupt not raised on period match");

    chk_stop_once: assert property (@(posedge ref_clk) disable iff (!rst_n)
        m_per && !ctrl_q.count_continue && !wr_ctrl |=> !ctrl_q.start)
        else $error("counter kept running without continue");

    chk_read_slot: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside its slot");

    // The trigger is registered, so it trails the period match by exactly one edge.
    chk_trig_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        m_per && ctrl_q.trig_en |=> conv_trig)
        else $error("converter trigger missing after period match");

    chk_ovf_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        evt.overflow |=> flags_q[`DCP_FLAG_OVF])
        else $error("overflow flag not set at wrap");

    // Cutoff only masks the pins; the internal levels keep running underneath.
    chk_cutoff_pins: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cut_act |=> (pwm_output_a == $past(ctrl_q.pol_a))
        && (pwm_output_b == $past(ctrl_q.pol_b)))
        else $error("pins not at initial level under cutoff");

    cov_period: cover property (@(posedge ref_clk) disable iff (!rst_n)
        m_per ##[1:1000] m_per);
    cov_overflow: cover property (@(posedge ref_clk) disable iff (!rst_n)
        evt.overflow);
    cov_cutoff: cover property (@(posedge ref_clk) disable iff (!rst_n)
        cut_act ##1 cut_act);
    cov_b_pulse: cover property (@(posedge ref_clk) disable iff (!rst_n)
        m_bset ##[1:1000] m_brst);
    cov_flag_clear: cover property (@(posedge ref_clk) disable iff (!rst_n)
        rd_flags && flags_q[0] ##[1:2] wr_flags && !reg_wdata[0]);
endmodule
`default_nettype wire

// ### tb/dcp_timer_bench.sv
// Self-checking bench for the dual compare PWM timer.
`timescale 1ns/1ps
`default_nettype none
`include "dcp_defs.svh"
module dcp_timer_bench;
    logic        ref_clk   = 1'b0;
    logic        rst_n     = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic        cutoff_in = 1'b0;
    logic [31:0] reg_rdata;
    logic        pwm_output_a;
    logic        pwm_output_b;
    logic        conv_trig;
    logic        irq;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          ha, hb, ra, rt, brise, n;
    logic        pa, pb;
    logic [31:0] got, held;
    logic [7:0]  offs [4] = '{`DCP_OFF_PERIOD, `DCP_OFF_ASET, `DCP_OFF_BRST, `DCP_OFF_BSET};
    logic [31:0] vals [4] = '{32'h9, 32'h6, 32'h7, 32'h2};

    always #4 ref_clk = ~ref_clk;

    dcp_timer dut (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .reg_addr     (reg_addr),
        .reg_wdata    (reg_wdata),
        .reg_wr       (reg_wr),
        .reg_rd       (reg_rd),
        .reg_rdata    (reg_rdata),
        .cutoff_in    (cutoff_in),
        .pwm_output_a (pwm_output_a),
        .pwm_output_b (pwm_output_b),
        .conv_trig    (conv_trig),
        .irq          (irq)
    );

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so it is caught right there.
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 got = reg_rdata;
    endtask

    task automatic measure();
        ha = 0; hb = 0; ra = 0; rt = 0; brise = -1;
        for (n = 0; n < 40; n++)
        begin
            pa = pwm_output_a;
            @(posedge ref_clk);
            #1;
            if (pa === 1'b0 && pwm_output_a === 1'b1)
                break;
        end
        if (n == 40)
        begin
            fail_count++;
            $display("[ERR] pwm_output_a rise expected 1 seen 0");
            test_done();
        end
        pb = pwm_output_b;
        // Twenty samples span exactly two periods of ten counts.
        for (n = 0; n < 20; n++)
        begin
            ha += (pwm_output_a === 1'b1);
            hb += (pwm_output_b === 1'b1);
            rt += (conv_trig === 1'b1);
            if (pa === 1'b0 && pwm_output_a === 1'b1)
                ra++;
            if (brise < 0 && pb === 1'b0 && pwm_output_b === 1'b1)
                brise = n;
            pa = pwm_output_a;
            pb = pwm_output_b;
            @(posedge ref_clk);
            #1;
        end
    endtask

    initial
    begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        chk("pins", 32'h0, {28'h0, pwm_output_a, pwm_output_b, conv_trig, irq});
        rd(`DCP_OFF_CTRL);    chk("ctrl", 32'h4, got);
        rd(`DCP_OFF_COUNTER); chk("counter", 32'h0, got);
        rd(`DCP_OFF_FLAGS);   chk("flags", 32'h0, got);
        wr(8'h24, 32'h5A5A5A5A);
        rd(8'h24);            chk("unmapped", 32'h0, got);
        for (int i = 0; i < 4; i++)
        begin
            rd(offs[i]); chk("cmp reset", 32'hFFFF, got);
            wr(offs[i], vals[i]);
        end
        for (int i = 0; i < 4; i++)
        begin
            rd(offs[i]); chk("cmp value", vals[i], got);
        end
        wr(`DCP_OFF_IRQ_MASK, 32'h1);
        wr(`DCP_OFF_CTRL, 32'h2007);
        measure();
        chk("a high", 32'(6), 32'(ha));
        chk("b high", 32'(10), 32'(hb));
        chk("a rises", 32'(2), 32'(ra));
        chk("b rise phase", 32'(6), 32'(brise));
        chk("trig pulses", 32'(2), 32'(rt));
        chk("irq", 32'h1, {31'h0, irq});
        wr(`DCP_OFF_CTRL, 32'h2006);
        wr(`DCP_OFF_FLAGS, 32'h0);
        rd(`DCP_OFF_FLAGS);   chk("flag unarmed", 32'h1, {31'h0, got[0]});
        wr(`DCP_OFF_FLAGS, 32'h0);
        rd(`DCP_OFF_FLAGS);   chk("flag cleared", 32'h0, {31'h0, got[0]});
        rd(`DCP_OFF_COUNTER);
        held = got;
        pa = pwm_output_a;
        pb = pwm_output_b;
        repeat (5) @(posedge ref_clk);
        rd(`DCP_OFF_COUNTER); chk("held count", held, got);
        chk("held pins", {30'h0, pa, pb}, {30'h0, pwm_output_a, pwm_output_b});
        wr(`DCP_OFF_IRQ_MASK, 32'h0);
        #1 chk("irq masked", 32'h0, {31'h0, irq});
        wr(`DCP_OFF_IRQ_MASK, 32'h1);
        #1 chk("irq unmasked", 32'h1, {31'h0, irq});
        rd(`DCP_OFF_IRQ_STAT); chk("stat period", 32'h1, {31'h0, got[0]});
        chk("irq after read", 32'h0, {31'h0, irq});
        rd(`DCP_OFF_IRQ_STAT); chk("stat cleared", 32'h0, got);
        wr(`DCP_OFF_CTRL, 32'h1007);
        @(posedge ref_clk);
        cutoff_in <= 1'b1;
        repeat (3) @(posedge ref_clk);
        ha = 0;
        repeat (12)
        begin
            @(posedge ref_clk);
            #1 ha += (pwm_output_a !== 1'b0) + (pwm_output_b !== 1'b0);
        end
        chk("cutoff pins", 32'h0, 32'(ha));
        @(posedge ref_clk);
        cutoff_in <= 1'b0;
        wr(`DCP_OFF_CTRL, 32'h0);
        wr(`DCP_OFF_COUNTER, 32'h0);
        wr(`DCP_OFF_CTRL, 32'h5);
        repeat (30) @(posedge ref_clk);
        rd(`DCP_OFF_CTRL);    chk("start dropped", 32'h0, {31'h0, got[0]});
        rd(`DCP_OFF_COUNTER); chk("cleared count", 32'h0, got);
        wr(`DCP_OFF_COUNTER, 32'h100);
        wr(`DCP_OFF_CTRL, 32'h3);
        wr(`DCP_OFF_CTRL, 32'h2);
        rd(`DCP_OFF_COUNTER); chk("two ticks", 32'h102, got);
        wr(`DCP_OFF_COUNTER, 32'hFFFC);
        wr(`DCP_OFF_CTRL, 32'h3);
        repeat (8) @(posedge ref_clk);
        rd(`DCP_OFF_FLAGS);   chk("overflow", 32'h1, {31'h0, got[1]});
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1 chk("pins rerun", 32'h0, {30'h0, pwm_output_a, pwm_output_b});
        rd(`DCP_OFF_CTRL);    chk("ctrl rerun", 32'h4, got);
        wr(`DCP_OFF_CTRL, 32'h1C);
        repeat (3) @(posedge ref_clk);
        #1 chk("inverted pins", 32'h3, {30'h0, pwm_output_a, pwm_output_b});
        test_done();
    end
endmodule
`default_nettype wire
